// ===== rtl/fcsm_map.vh
// Purpose: Constants for the flash command host controller
// Assumes: Byte-wide flash with 19 address lines, JEDEC style unlock cycles
// Notes: Command codes and unlock addresses are plain defaults, override if needed
`ifndef FCSM_MAP_VH
`define FCSM_MAP_VH
// Unlock addresses and data
`define FCSM_UNLOCK_ADDR1 19'h0_5555
`define FCSM_UNLOCK_ADDR2 19'h0_2AAA
`define FCSM_UNLOCK_DATA1 8'hAA
`define FCSM_UNLOCK_DATA2 8'h55
// Command codes
`define FCSM_CMD_PROGRAM 8'hA0
`define FCSM_CMD_ERASE_SETUP 8'h80
`define FCSM_CMD_CHIP_ERASE 8'h10
`define FCSM_CMD_SECTOR_ERASE 8'h30
`define FCSM_CMD_PAGE_ERASE 8'h50
`define FCSM_CMD_ID_ENTRY 8'h90
`define FCSM_CMD_ID_EXIT 8'hF0
// Identification read addresses (low byte)
`define FCSM_ID_MAKER_ADDR 19'h0_0000
`define FCSM_ID_PART_ADDR 19'h0_0001
// Operation codes on the user port
`define FCSM_OP_READ 3'h0
`define FCSM_OP_PROGRAM 3'h1
`define FCSM_OP_CHIP_ERASE 3'h2
`define FCSM_OP_SECTOR_ERASE 3'h3
`define FCSM_OP_PAGE_ERASE 3'h4
`define FCSM_OP_ID_ENTRY 3'h5
`define FCSM_OP_ID_EXIT3 3'h6
`define FCSM_OP_ID_EXIT1 3'h7
// Status bit positions
`define FCSM_POLL_BIT 7
`define FCSM_TOGGLE_BIT 6
// Bus cycle phase counter loads; each phase lasts one clock more than its value (25 ns each)
`define FCSM_SETUP_CYC 4'h2
`define FCSM_STROBE_CYC 4'h3
`define FCSM_HOLD_CYC 4'h2
`define FCSM_READ_CYC 4'h4
`endif

// ===== rtl/fcsm_bus_cycle.v
// Purpose: One strobe cycle on the flash bus, read or write
// Assumes: Inputs synchronous to i_mclk
// Notes: Address set up before the strobe falls, data held past its rise
`include "fcsm_map.vh"
module fcsm_bus_cycle #(
   parameter AW = 19,
   parameter DW = 8
) (
   // Clock and reset
   input wire i_mclk,
   input wire i_rst,
   // Request
   input wire i_go,
   input wire i_wr,
   input wire [AW-1:0] i_addr,
   input wire [DW-1:0] i_wdata,
   // Answer
   output reg o_done,
   output reg [DW-1:0] o_rdata,
   // Flash pins
   output reg [AW-1:0] o_fa,
   output reg o_ce_n,
   output reg o_oe_n,
   output reg o_we_n,
   output reg [DW-1:0] o_dq_out,
   output reg o_dq_oe,
   input wire [DW-1:0] i_dq_in
);
   localparam S_IDLE = 2'd0;
   localparam S_SETUP = 2'd1;
   localparam S_STROBE = 2'd2;
   localparam S_HOLD = 2'd3;
   reg [1:0] st_ff;
   reg [3:0] cnt_ff;
   reg wr_ff;
   always @(posedge i_mclk or posedge i_rst) begin
      if (i_rst) begin
         st_ff <= S_IDLE;
         cnt_ff <= 4'h0;
         wr_ff <= 1'b0;
         o_done <= 1'b0;
         o_rdata <= {DW{1'b0}};
         o_fa <= {AW{1'b0}};
         o_ce_n <= 1'b1;
         o_oe_n <= 1'b1;
         o_we_n <= 1'b1;
         o_dq_out <= {DW{1'b0}};
         o_dq_oe <= 1'b0;
      end else begin
         o_done <= 1'b0;
         case (st_ff)
            S_IDLE: begin
               if (i_go) begin
                  // Address stands before the later falling strobe
                  o_fa <= i_addr;
                  o_dq_out <= i_wdata;
                  o_dq_oe <= i_wr;
                  wr_ff <= i_wr;
                  cnt_ff <= `FCSM_SETUP_CYC;
                  st_ff <= S_SETUP;
               end
            end
            S_SETUP: begin
               if (cnt_ff == 4'h0) begin
                  o_ce_n <= 1'b0;
                  o_we_n <= ~wr_ff;
                  o_oe_n <= wr_ff;
                  cnt_ff <= wr_ff ? `FCSM_STROBE_CYC : `FCSM_READ_CYC;
                  st_ff <= S_STROBE;
               end else begin
                  cnt_ff <= cnt_ff - 4'h1;
               end
            end
            S_STROBE: begin
               if (cnt_ff == 4'h0) begin
                  // Data sampled at the strobe rise, held valid through hold phase
                  o_rdata <= i_dq_in;
                  o_ce_n <= 1'b1;
                  o_we_n <= 1'b1;
                  o_oe_n <= 1'b1;
                  cnt_ff <= `FCSM_HOLD_CYC;
                  st_ff <= S_HOLD;
               end else begin
                  cnt_ff <= cnt_ff - 4'h1;
               end
            end
            S_HOLD: begin
               if (cnt_ff == 4'h0) begin
                  o_dq_oe <= 1'b0;
                  o_done <= 1'b1;
                  st_ff <= S_IDLE;
               end else begin
                  cnt_ff <= cnt_ff - 4'h1;
               end
            end
            default: st_ff <= S_IDLE;
         endcase
      end
   end
endmodule // fcsm_bus_cycle

// ===== rtl/fcsm_host.v
// Purpose: Host controller that drives a byte-wide flash through its command sequences
// Assumes: Flash pins and user inputs synchronous to i_mclk; one operation at a time
// Notes: Polls the busy flash with reads until the toggle status bit stands still
`include "fcsm_map.vh"
module fcsm_host #(
   parameter AW = 19,
   parameter DW = 8,
   parameter POLL_LIMIT = 24'd4_000_000
) (
   // Clock and reset
   input wire i_mclk,
   input wire i_rst,
   // User request
   input wire i_req,
   input wire [2:0] i_op,
   input wire [AW-1:0] i_addr,
   input wire [DW-1:0] i_wdata,
   // User answer
   output reg o_busy,
   output reg o_done,
   output reg o_error,
   output reg [DW-1:0] o_rdata,
   output reg o_id_mode,
   // Flash pins
   output wire [AW-1:0] o_fa,
   output wire o_ce_n,
   output wire o_oe_n,
   output wire o_we_n,
   output wire [DW-1:0] o_dq_out,
   output wire o_dq_oe,
   input wire [DW-1:0] i_dq_in
);
   localparam S_IDLE = 3'd0;
   localparam S_WRITE = 3'd1;
   localparam S_POLL = 3'd2;
   localparam S_FINAL = 3'd3;
   localparam S_WAIT = 3'd4;
   localparam S_READ = 3'd5;
   localparam S_LAUNCH = 3'd6;
   reg [2:0] st_ff;
   reg [2:0] op_ff;
   reg [2:0] step_ff;
   reg [AW-1:0] addr_ff;
   reg [DW-1:0] data_ff;
   reg [DW-1:0] last_ff;
   reg first_ff;
   reg [23:0] poll_cnt_ff;
   reg go_ff;
   reg wr_ff;
   reg [AW-1:0] cyc_addr_ff;
   reg [DW-1:0] cyc_data_ff;
   reg busy_erase_ff;
   wire cyc_done;
   wire [DW-1:0] cyc_rdata;
   reg [2:0] nxt_len;
   reg [AW-1:0] nxt_addr;
   reg [DW-1:0] nxt_data;
   fcsm_bus_cycle #(.AW(AW), .DW(DW)) u_cycle (
      .i_mclk(i_mclk),
      .i_rst(i_rst),
      .i_go(go_ff),
      .i_wr(wr_ff),
      .i_addr(cyc_addr_ff),
      .i_wdata(cyc_data_ff),
      .o_done(cyc_done),
      .o_rdata(cyc_rdata),
      .o_fa(o_fa),
      .o_ce_n(o_ce_n),
      .o_oe_n(o_oe_n),
      .o_we_n(o_we_n),
      .o_dq_out(o_dq_out),
      .o_dq_oe(o_dq_oe),
      .i_dq_in(i_dq_in)
   );
   // Sequence table: length and the address and data of each write step
   always @* begin
      nxt_len = 3'd1;
      nxt_addr = `FCSM_UNLOCK_ADDR1;
      nxt_data = `FCSM_UNLOCK_DATA1;
      case (op_ff)
         `FCSM_OP_PROGRAM: nxt_len = 3'd4;
         `FCSM_OP_CHIP_ERASE, `FCSM_OP_SECTOR_ERASE, `FCSM_OP_PAGE_ERASE: nxt_len = 3'd6;
         `FCSM_OP_ID_ENTRY, `FCSM_OP_ID_EXIT3: nxt_len = 3'd3;
         default: nxt_len = 3'd1;
      endcase
      case (step_ff)
         3'd0, 3'd3: begin
            nxt_addr = `FCSM_UNLOCK_ADDR1;
            nxt_data = `FCSM_UNLOCK_DATA1;
         end
         3'd1, 3'd4: begin
            nxt_addr = `FCSM_UNLOCK_ADDR2;
            nxt_data = `FCSM_UNLOCK_DATA2;
         end
         default: begin
            nxt_addr = `FCSM_UNLOCK_ADDR1;
            nxt_data = `FCSM_CMD_ERASE_SETUP;
         end
      endcase
      if (step_ff == 3'd2) begin
         case (op_ff)
            `FCSM_OP_PROGRAM: nxt_data = `FCSM_CMD_PROGRAM;
            `FCSM_OP_ID_ENTRY: nxt_data = `FCSM_CMD_ID_ENTRY;
            `FCSM_OP_ID_EXIT3: nxt_data = `FCSM_CMD_ID_EXIT;
            default: nxt_data = `FCSM_CMD_ERASE_SETUP;
         endcase
      end
      if (op_ff == `FCSM_OP_PROGRAM && step_ff == 3'd3) begin
         nxt_addr = addr_ff;
         nxt_data = data_ff;
      end
      if (step_ff == 3'd5) begin
         case (op_ff)
            `FCSM_OP_SECTOR_ERASE: begin
               nxt_addr = addr_ff;
               nxt_data = `FCSM_CMD_SECTOR_ERASE;
            end
            `FCSM_OP_PAGE_ERASE: begin
               nxt_addr = addr_ff;
               nxt_data = `FCSM_CMD_PAGE_ERASE;
            end
            default: nxt_data = `FCSM_CMD_CHIP_ERASE;
         endcase
      end
      if (op_ff == `FCSM_OP_ID_EXIT1) begin
         nxt_addr = addr_ff;
         nxt_data = `FCSM_CMD_ID_EXIT;
      end
   end
   always @(posedge i_mclk or posedge i_rst) begin
      if (i_rst) begin
         st_ff <= S_IDLE;
         op_ff <= `FCSM_OP_READ;
         step_ff <= 3'd0;
         addr_ff <= {AW{1'b0}};
         data_ff <= {DW{1'b0}};
         last_ff <= {DW{1'b0}};
         first_ff <= 1'b0;
         poll_cnt_ff <= 24'h00_0000;
         go_ff <= 1'b0;
         wr_ff <= 1'b0;
         cyc_addr_ff <= {AW{1'b0}};
         cyc_data_ff <= {DW{1'b0}};
         busy_erase_ff <= 1'b0;
         o_busy <= 1'b0;
         o_done <= 1'b0;
         o_error <= 1'b0;
         o_rdata <= {DW{1'b0}};
         o_id_mode <= 1'b0;
      end else begin
         go_ff <= 1'b0;
         o_done <= 1'b0;
         case (st_ff)
            S_IDLE: begin
               if (i_req) begin
                  op_ff <= i_op;
                  addr_ff <= i_addr;
                  data_ff <= i_wdata;
                  step_ff <= 3'd0;
                  o_busy <= 1'b1;
                  o_error <= 1'b0;
                  st_ff <= (i_op == `FCSM_OP_READ) ? S_READ : S_LAUNCH;
               end
            end
            S_READ: begin
               // Array byte, or id code when id mode is active
               cyc_addr_ff <= addr_ff;
               wr_ff <= 1'b0;
               go_ff <= 1'b1;
               st_ff <= S_WAIT;
            end
            S_WAIT: begin
               if (cyc_done) begin
                  o_rdata <= cyc_rdata;
                  o_busy <= 1'b0;
                  o_done <= 1'b1;
                  st_ff <= S_IDLE;
               end
            end
            S_LAUNCH: begin
               // Each step loads its own address and data before go, never a stale step
               cyc_addr_ff <= nxt_addr;
               cyc_data_ff <= nxt_data;
               wr_ff <= 1'b1;
               go_ff <= 1'b1;
               st_ff <= S_WRITE;
            end
            S_WRITE: begin
               if (cyc_done) begin
                  if (step_ff == nxt_len - 3'd1) begin
                     if (op_ff == `FCSM_OP_ID_ENTRY) begin
                        o_id_mode <= 1'b1;
                     end
                     if (op_ff == `FCSM_OP_ID_EXIT3 || op_ff == `FCSM_OP_ID_EXIT1) begin
                        o_id_mode <= 1'b0;
                     end
                     if (op_ff == `FCSM_OP_PROGRAM || nxt_len == 3'd6) begin
                        // Busy flash gets reads only, never a command
                        busy_erase_ff <= (nxt_len == 3'd6);
                        first_ff <= 1'b1;
                        poll_cnt_ff <= 24'h00_0000;
                        st_ff <= S_POLL;
                     end else begin
                        o_busy <= 1'b0;
                        o_done <= 1'b1;
                        st_ff <= S_IDLE;
                     end
                  end else begin
                     step_ff <= step_ff + 3'd1;
                     st_ff <= S_LAUNCH;
                  end
               end
            end
            S_POLL: begin
               // Poll at the programmed byte or inside the erased region
               cyc_addr_ff <= addr_ff;
               wr_ff <= 1'b0;
               go_ff <= 1'b1;
               st_ff <= S_FINAL;
            end
            S_FINAL: begin
               if (cyc_done) begin
                  last_ff <= cyc_rdata;
                  first_ff <= 1'b0;
                  poll_cnt_ff <= poll_cnt_ff + 24'h00_0001;
                  if (!first_ff &&
                      cyc_rdata[`FCSM_TOGGLE_BIT] == last_ff[`FCSM_TOGGLE_BIT]) begin
                     // Toggle stopped: flash back in array read, take a clean byte
                     st_ff <= S_READ;
                     if (busy_erase_ff ? ~cyc_rdata[`FCSM_POLL_BIT]
                         : (cyc_rdata[`FCSM_POLL_BIT] != data_ff[`FCSM_POLL_BIT])) begin
                        o_error <= 1'b1;
                     end
                  end else if (poll_cnt_ff == POLL_LIMIT) begin
                     o_error <= 1'b1;
                     st_ff <= S_READ;
                  end else begin
                     st_ff <= S_POLL;
                  end
               end
            end
            default: st_ff <= S_IDLE;
         endcase
      end
   end
endmodule // fcsm_host

// ===== tb/fcsm_host_props.sv
// Purpose: Port checks for the flash host controller
// Assumes: One clock i_mclk, async reset i_rst
// Notes: Strobe widths follow the hand-over bus cycle walk
module fcsm_host_props (
   input wire i_mclk,
   input wire i_rst,
   input wire i_req,
   input wire o_busy,
   input wire o_done,
   input wire o_id_mode,
   input wire [18:0] o_fa,
   input wire o_ce_n,
   input wire o_oe_n,
   input wire o_we_n,
   input wire [7:0] o_dq_out,
   input wire o_dq_oe
);
   timeunit 1ns;
   timeprecision 100ps;
   default clocking @(posedge i_mclk); endclocking
   default disable iff (i_rst);
   sequence seq_write_low;
      !o_we_n [*4] ##1 o_we_n;
   endsequence
   sequence seq_read_low;
      !o_oe_n [*5] ##1 o_oe_n;
   endsequence
   a_write_pulse_len: assert property ($fell(o_we_n) |-> seq_write_low)
      else $error("write strobe width wrong");
   a_read_pulse_len: assert property ($fell(o_oe_n) |-> seq_read_low)
      else $error("read strobe width wrong");
   a_write_fields_held: assert property (!o_we_n |=> $stable(o_fa) && $stable(o_dq_out))
      else $error("address or data moved under write strobe");
   a_write_drive_on: assert property (!o_we_n |-> !o_ce_n && o_oe_n && o_dq_oe)
      else $error("write strobe without select or drive");
   a_read_bus_free: assert property (!o_oe_n |-> !o_ce_n && o_we_n && !o_dq_oe)
      else $error("read strobe while host drives data");
   a_idle_bus_quiet: assert property (!o_busy |-> o_ce_n && o_oe_n && o_we_n)
      else $error("strobe active while idle");
   a_done_in_time: assert property (i_req && !o_busy |-> ##[10:1000] o_done)
      else $error("operation did not finish in time");
   a_done_one_cycle: assert property (o_done |=> !o_done && !o_busy)
      else $error("done pulse too long");
   a_id_mode_change: assert property ($changed(o_id_mode) |-> o_done)
      else $error("id mode changed without completion");
endmodule // fcsm_host_props

bind fcsm_host fcsm_host_props u_fcsm_host_props (.i_mclk, .i_rst, .i_req, .o_busy,
   .o_done, .o_id_mode, .o_fa, .o_ce_n, .o_oe_n, .o_we_n, .o_dq_out, .o_dq_oe);

// ===== tb/fcsm_flash_model.sv
// Purpose: Behavioural byte-wide flash that answers the host controller
// Assumes: Busy time counted in status reads, set by the bench
// Notes: Released data lines show the inverse of the last byte, not a held value
module fcsm_flash_model #(
   parameter logic [7:0] MAKER_ID = 8'h3C, // Arbitrary value
   parameter logic [7:0] PART_ID = 8'hC3 // Arbitrary value
) (
   input wire logic [18:0] i_fa,
   input wire logic i_ce_n,
   input wire logic i_oe_n,
   input wire logic i_we_n,
   input wire logic [7:0] i_dq,
   input wire logic [7:0] i_busy_reads,
   output logic [7:0] o_dq
);
   timeunit 1ns;
   timeprecision 100ps;
   logic [7:0] mem [int];
   logic [18:0] cmd_a;
   logic [7:0] last_d, last_q = 8'h00;
   int cyc = 0, nxt, busy_left = 0;
   logic id_mode = 0, prog_run = 0, tog = 0;
   wire wr_n = i_we_n | i_ce_n;
   wire rd_n = i_oe_n | i_ce_n;
   function automatic logic [7:0] arr(input int a);
      return mem.exists(a) ? mem[a] : 8'hFF;
   endfunction
   task automatic erase(input logic [7:0] d);
      int q[$];
      foreach (mem[k])
         if (d == 8'h10 || (d == 8'h30 && k[18:16] == cmd_a[18:16]) ||
            (d == 8'h50 && k[18:12] == cmd_a[18:12]))
            q.push_back(k);
      foreach (q[i]) mem.delete(q[i]);
      prog_run = 0;
      busy_left = i_busy_reads;
   endtask
   always @(negedge wr_n) cmd_a = i_fa;
   always @(posedge wr_n) begin : cmd_step
      logic a5, un1, un2;
      a5 = cmd_a[14:0] == 15'h5555;
      un1 = a5 && i_dq == 8'hAA;
      un2 = cmd_a[14:0] == 15'h2AAA && i_dq == 8'h55;
      nxt = 0;
      if (busy_left == 0) begin
         if (cyc == 0 && i_dq == 8'hF0) id_mode = 0;
         else if (cyc == 3) begin
            last_d = i_dq;
            prog_run = 1;
            busy_left = (i_dq & ~arr(cmd_a)) != 0 ? 0 : i_busy_reads;
            mem[cmd_a] = arr(cmd_a) & i_dq;
         end else if ((cyc == 0 || cyc == 4) && un1 || (cyc == 1 || cyc == 5) && un2) nxt = cyc + 1;
         else if (cyc == 2 && a5) begin
            if (i_dq == 8'hA0) nxt = 3;
            if (i_dq == 8'h80) nxt = 4;
            if (i_dq == 8'h90) id_mode = 1;
            if (i_dq == 8'hF0) id_mode = 0;
         end else if (cyc == 6 && (a5 && i_dq == 8'h10 || i_dq == 8'h30 || i_dq == 8'h50))
            erase(i_dq);
         cyc = nxt;
      end
   end
   always @(negedge rd_n) begin
      if (busy_left != 0) begin
         tog = ~tog;
         last_q = {prog_run ? ~last_d[7] : 1'b0, tog, 6'h2A};
         busy_left = busy_left - 1;
      end else if (id_mode && i_fa[7:1] == 7'h00) last_q = i_fa[0] ? PART_ID : MAKER_ID;
      else last_q = arr(i_fa);
   end
   assign o_dq = rd_n ? ~last_q : last_q;
endmodule // fcsm_flash_model

// ===== tb/fcsm_host_tb_top.sv
// Purpose: Self-checking bench for the flash host controller
// Assumes: Flash model answers on the strobes
// Notes: Poll limit cut to 20, so the host gives up after 21 status reads and the run stays short
`include "fcsm_map.vh"
module fcsm_host_tb_top;
   timeunit 1ns;
   timeprecision 100ps;
   localparam logic [7:0] MAKER = 8'h3C;
   localparam logic [7:0] PART = 8'hC3;
   logic i_mclk, i_rst, i_req, o_busy, o_done, o_error, o_id_mode;
   logic [2:0] i_op;
   logic [18:0] i_addr, o_fa;
   logic [7:0] i_wdata, o_rdata, o_dq_out, flash_dq, busy_reads;
   logic o_ce_n, o_oe_n, o_we_n, o_dq_oe;
   wire [7:0] dq_in = o_dq_oe ? o_dq_out : flash_dq;
   int num_errors = 0, checked = 0;
   fcsm_host #(.POLL_LIMIT(24'd20)) u_fcsm_host (.i_mclk, .i_rst, .i_req, .i_op, .i_addr,
      .i_wdata, .o_busy, .o_done, .o_error, .o_rdata, .o_id_mode, .o_fa, .o_ce_n, .o_oe_n,
      .o_we_n, .o_dq_out, .o_dq_oe, .i_dq_in(dq_in));
   fcsm_flash_model #(.MAKER_ID(MAKER), .PART_ID(PART)) u_fcsm_flash_model (.i_fa(o_fa),
      .i_ce_n(o_ce_n), .i_oe_n(o_oe_n), .i_we_n(o_we_n), .i_dq(o_dq_out),
      .i_busy_reads(busy_reads), .o_dq(flash_dq));
   initial begin
      i_mclk = 0;
      forever #12.5 i_mclk = ~i_mclk;
   end
   task automatic check(input logic [7:0] got, input logic [7:0] exp);
      checked++;
      if (got !== exp) begin
         num_errors++;
         $display("BAD %0t got %h want %h", $time, got, exp);
      end
   endtask
   task automatic run_op(input logic [2:0] op, input logic [18:0] a, input logic [7:0] d);
      int n;
      @(posedge i_mclk) #1;
      i_req = 1;
      i_op = op;
      i_addr = a;
      i_wdata = d;
      @(posedge i_mclk) #1;
      i_req = 0;
      n = 0;
      while (o_done !== 1'b1 && n < 2000) begin
         @(posedge i_mclk) #1;
         n++;
      end
      check({7'h00, o_done}, 8'h01);
   endtask
   task automatic rd_chk(input logic [18:0] a, input logic [7:0] exp);
      run_op(`FCSM_OP_READ, a, 8'h00);
      check(o_rdata, exp);
   endtask
   task automatic t_prog();
      rd_chk(19'h1_0FFF, 8'hFF);
      busy_reads = 8'h01;
      run_op(`FCSM_OP_PROGRAM, 19'h1_0FFF, 8'h5A);
      check({7'h00, o_error}, 8'h00);
      check(o_rdata, 8'h5A);
      busy_reads = 8'h08;
      run_op(`FCSM_OP_PROGRAM, 19'h0_FFFF, 8'hA5);
      check({7'h00, o_error}, 8'h00);
      rd_chk(19'h1_0FFF, 8'h5A);
      rd_chk(19'h0_FFFF, 8'hA5);
      run_op(`FCSM_OP_PROGRAM, 19'h1_0FFF, 8'hDA);
      check({7'h00, o_error}, 8'h01);
      check(o_rdata, 8'h5A);
      $display("t_prog done");
   endtask
   task automatic t_erase();
      busy_reads = 8'h03;
      run_op(`FCSM_OP_PROGRAM, 19'h5_0001, 8'h11);
      run_op(`FCSM_OP_PROGRAM, 19'h6_0002, 8'h22);
      run_op(`FCSM_OP_PROGRAM, 19'h6_F000, 8'h33);
      run_op(`FCSM_OP_SECTOR_ERASE, 19'h5_ABCD, 8'h00);
      check({7'h00, o_error}, 8'h00);
      rd_chk(19'h5_0001, 8'hFF);
      rd_chk(19'h6_0002, 8'h22);
      run_op(`FCSM_OP_PAGE_ERASE, 19'h6_0ABC, 8'h00);
      rd_chk(19'h6_0002, 8'hFF);
      rd_chk(19'h6_F000, 8'h33);
      run_op(`FCSM_OP_CHIP_ERASE, 19'h0_0000, 8'h00);
      check({7'h00, o_error}, 8'h00);
      rd_chk(19'h6_F000, 8'hFF);
      rd_chk(19'h0_FFFF, 8'hFF);
      $display("t_erase done");
   endtask
   task automatic t_ident();
      run_op(`FCSM_OP_ID_ENTRY, 19'h0_0000, 8'h00);
      check({7'h00, o_id_mode}, 8'h01);
      rd_chk(19'h7_3300, MAKER);
      rd_chk(19'h0_0401, PART);
      run_op(`FCSM_OP_ID_EXIT3, 19'h0_0000, 8'h00);
      check({7'h00, o_id_mode}, 8'h00);
      rd_chk(19'h0_0401, 8'hFF);
      run_op(`FCSM_OP_ID_ENTRY, 19'h0_0000, 8'h00);
      run_op(`FCSM_OP_ID_EXIT1, 19'h1_2345, 8'h00);
      check({7'h00, o_id_mode}, 8'h00);
      rd_chk(19'h0_0000, 8'hFF);
      run_op(`FCSM_OP_ID_ENTRY, 19'h0_0000, 8'h00);
      run_op(`FCSM_OP_ID_EXIT3, 19'h0_0000, 8'h00);
      check({7'h00, o_id_mode}, 8'h00);
      rd_chk(19'h0_0001, 8'hFF);
      $display("t_ident done");
   endtask
   task automatic complete_run();
      $display("checks %0d mismatches %0d", checked, num_errors);
      if (num_errors == 0 && checked > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   initial begin
      i_rst = 1;
      i_req = 0;
      i_op = 3'h0;
      i_addr = 19'h0_0000;
      i_wdata = 8'h00;
      busy_reads = 8'h01;
      repeat (10) @(posedge i_mclk);
      #1 i_rst = 0;
      t_prog();
      t_erase();
      t_ident();
      complete_run();
   end
   initial begin
      #(60000 * 25);
      num_errors++;
      $display("BAD %0t watchdog expired", $time);
      complete_run();
   end
endmodule // fcsm_host_tb_top
